// [rtl/cmb_regs.svh]
`ifndef CMB_REGS_SVH
`define CMB_REGS_SVH
`define CMB_NMB        32
`define CMB_MB_PAGE    2'h0
`define CMB_GLB_PAGE   4'h4
`define CMB_OFF_ID     5'h00
`define CMB_OFF_CTL    5'h08
`define CMB_OFF_EN     8'h00
`define CMB_OFF_DIR    8'h08
`define CMB_OFF_TQSET  8'h10
`define CMB_OFF_TQCLR  8'h18
`define CMB_OFF_RXPEND 8'h30
`define CMB_OFF_LMASK  8'h40
`define CMB_OFF_GMASK  8'h48
`define CMB_OFF_RMPEND 8'hA0
`define CMB_OFF_TSC    8'hB8
`define CMB_F_IDE      31
`define CMB_F_MSKEN    30
`define CMB_F_ARR      29
`define CMB_F_RTR      4
`define CMB_STD_LSB    18
`define CMB_TS_LSB     16
`define CMB_CTL_WMASK  32'hFFFF_001F
`define CMB_EN_RST     32'h0000_0000
`define CMB_DIR_RST    32'h8000_0000
`define CMB_MASK_RST   32'h0000_0000
`endif

// [rtl/cmb_pkg.sv]
package cmb_pkg;
	typedef enum {
		CMB_SEL_NONE, CMB_SEL_ID, CMB_SEL_CTL, CMB_SEL_EN, CMB_SEL_DIR,
		CMB_SEL_TQSET, CMB_SEL_TQCLR, CMB_SEL_RXP, CMB_SEL_LMASK,
		CMB_SEL_GMASK, CMB_SEL_RMP, CMB_SEL_TSC
	} cmb_sel_t;
	typedef logic [4:0] cmb_mbx_t;
endpackage

// [rtl/cmb_accept.sv]
`timescale 1ns/1ps
`include "cmb_regs.svh"
module cmb_accept import cmb_pkg::*; #(
	parameter int NMB = `CMB_NMB
) (
	input  logic [NMB*32-1:0] id_flat,
	input  logic [NMB-1:0]    en,
	input  logic [NMB-1:0]    dir_rx,
	input  logic [31:0]       gmask,
	input  logic [31:0]       lmask,
	input  logic              rx_ide,
	input  logic              rx_rtr,
	input  logic [28:0]       rx_id,
	output logic [NMB-1:0]    hit
);
	genvar i;
	generate
		for (i = 0; i < NMB; i++) begin : g_mb
			wire [31:0] w    = id_flat[i*32 +: 32];
			// a set mask bit means "don't care"
			wire [28:0] m    = (i == NMB-1) ? lmask[28:0] : gmask[28:0];
			wire [28:0] msk  = w[`CMB_F_MSKEN] ? m : 29'h0;
			wire [28:0] care = w[`CMB_F_IDE] ? ~msk : {~msk[28:`CMB_STD_LSB], 18'h0};
			wire        idm  = (((w[28:0] ^ rx_id) & care) == 29'h0) && (w[`CMB_F_IDE] == rx_ide);
			// transmit mailboxes only react to remote frames
			assign hit[i] = en[i] && idm && (dir_rx[i] || rx_rtr);
		end
	endgenerate
endmodule

// [rtl/cmb_id_prio.sv]
`timescale 1ns/1ps
`include "cmb_regs.svh"
module cmb_id_prio import cmb_pkg::*; #(
	parameter int NMB = `CMB_NMB
) (
	input  logic [NMB*32-1:0] id_flat,
	input  logic [NMB-1:0]    cand,
	output logic              any,
	output cmb_mbx_t          sel
);
	function automatic logic [4:0] zrun(input logic [28:0] v);
		logic [4:0] n;
		logic       stop;
		n = 5'h0;
		stop = 1'b0;
		for (int b = 28; b >= 0; b--) begin
			if (!stop && !v[b]) n = n + 5'h1;
			else stop = 1'b1;
		end
		return n;
	endfunction
	logic [4:0] run [NMB];
	logic [4:0] best;
	genvar i;
	generate
		for (i = 0; i < NMB; i++) begin : g_run
			wire [31:0] w = id_flat[i*32 +: 32];
			// standard ids rank on their 11 used bits only
			assign run[i] = zrun(w[`CMB_F_IDE] ? w[28:0] : {w[28:`CMB_STD_LSB], 18'h3FFFF});
		end
	endgenerate
	always_comb begin
		any = 1'b0;
		sel = 5'h0;
		best = 5'h0;
		for (int k = 0; k < NMB; k++) begin
			// strict compare: ties go to the lower mailbox number
			if (cand[k] && (!any || run[k] > best)) begin
				any = 1'b1;
				sel = 5'(k);
				best = run[k];
			end
		end
	end
endmodule

// [rtl/cmb_mailbox.sv]
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "cmb_regs.svh"
module cmb_mailbox import cmb_pkg::*; #(
	parameter int NMB = `CMB_NMB
) (
	input  logic        pclk,
	input  logic        presetn,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [11:0] paddr,
	input  logic [31:0] pwdata,
	output logic        pready,
	output logic [31:0] prdata,
	output logic        pslverr,
	input  logic        rx_valid,
	input  logic        rx_ide,
	input  logic        rx_rtr,
	input  logic [28:0] rx_id,
	input  logic [3:0]  rx_dlc,
	input  logic        tx_done,
	input  logic        tx_ok,
	input  cmb_mbx_t    tx_mbox,
	output logic        tx_pend,
	output cmb_mbx_t    tx_sel,
	output logic        tx_ide,
	output logic        tx_rtr,
	output logic [28:0] tx_id,
	output logic [3:0]  tx_dlc,
	output logic [31:0] mbox_en,
	output logic [31:0] treq,
	output logic [31:0] rxpend,
	output logic [31:0] rmtpend,
	output logic [15:0] tstamp
);
	////////////////////////////////////////////////////////////////
	// storage: no reset on the mailbox words
	logic [31:0] id_r  [NMB];
	logic [31:0] ctl_r [NMB];
	logic [31:0] en_r;
	logic [31:0] dir_r;
	logic [31:0] treq_r;
	logic [31:0] treq_nxt;
	logic [31:0] rxp_r;
	logic [31:0] rxp_nxt;
	logic [31:0] rmp_r;
	logic [31:0] rmp_nxt;
	logic [31:0] gmask_r;
	logic [31:0] lmask_r;
	logic [15:0] ts_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_nxt;
	logic        tx_pend_r;
	cmb_mbx_t    tx_sel_r;
	logic        tx_ide_r;
	logic        tx_rtr_r;
	logic [28:0] tx_id_r;
	logic [3:0]  tx_dlc_r;
	logic [NMB*32-1:0] id_flat;
	logic [NMB-1:0]    hit;
	logic              rx_any;
	cmb_mbx_t          rx_win;
	logic              pr_any;
	cmb_mbx_t          pr_sel;
	cmb_sel_t          sel;

	////////////////////////////////////////////////////////////////
	// address decode
	wire       is_mb   = paddr[11:10] == `CMB_MB_PAGE;
	wire       is_glb  = paddr[11:8] == `CMB_GLB_PAGE;
	cmb_mbx_t  mb;
	assign mb = paddr[9:5];
	wire [4:0] mb_off  = paddr[4:0];
	wire [7:0] g_off   = paddr[7:0];
	assign sel =
		(is_mb && mb_off == `CMB_OFF_ID) ? CMB_SEL_ID :
		(is_mb && mb_off == `CMB_OFF_CTL) ? CMB_SEL_CTL :
		(is_glb && g_off == `CMB_OFF_EN) ? CMB_SEL_EN :
		(is_glb && g_off == `CMB_OFF_DIR) ? CMB_SEL_DIR :
		(is_glb && g_off == `CMB_OFF_TQSET) ? CMB_SEL_TQSET :
		(is_glb && g_off == `CMB_OFF_TQCLR) ? CMB_SEL_TQCLR :
		(is_glb && g_off == `CMB_OFF_RXPEND) ? CMB_SEL_RXP :
		(is_glb && g_off == `CMB_OFF_LMASK) ? CMB_SEL_LMASK :
		(is_glb && g_off == `CMB_OFF_GMASK) ? CMB_SEL_GMASK :
		(is_glb && g_off == `CMB_OFF_RMPEND) ? CMB_SEL_RMP :
		(is_glb && g_off == `CMB_OFF_TSC) ? CMB_SEL_TSC :
		CMB_SEL_NONE;
	wire setup = psel && !penable;
	wire acc   = psel && penable;
	wire wr    = acc && pwrite;
	assign pready  = 1'b1;
	assign pslverr = acc && (sel == CMB_SEL_NONE);
	assign prdata  = prdata_r;

	wire wr_id   = wr && sel == CMB_SEL_ID;
	wire wr_ctl  = wr && sel == CMB_SEL_CTL;
	// identifier is frozen while the mailbox is enabled
	wire id_ok   = !en_r[mb];
	// an enabled auto-reply transmit mailbox also freezes its control
	wire ctl_ok  = !(en_r[mb] && !dir_r[mb] && id_r[mb][`CMB_F_ARR]);
	wire [31:0] wr_set = (wr && sel == CMB_SEL_TQSET) ? pwdata : 32'h0;
	wire [31:0] wr_tclr = (wr && sel == CMB_SEL_TQCLR) ? pwdata : 32'h0;
	wire [31:0] wr_rxc = (wr && sel == CMB_SEL_RXP) ? pwdata : 32'h0;
	wire [31:0] wr_rmc = (wr && sel == CMB_SEL_RMP) ? pwdata : 32'h0;

	////////////////////////////////////////////////////////////////
	// read mux; data is captured in the setup cycle
	always_comb begin
		case (sel)
			CMB_SEL_ID:    rd_nxt = id_r[mb];
			// reserved control bits read back as zero
			CMB_SEL_CTL:   rd_nxt = ctl_r[mb] & `CMB_CTL_WMASK;
			CMB_SEL_EN:    rd_nxt = en_r;
			CMB_SEL_DIR:   rd_nxt = dir_r;
			CMB_SEL_TQSET: rd_nxt = treq_r;
			CMB_SEL_TQCLR: rd_nxt = treq_r;
			CMB_SEL_RXP:   rd_nxt = rxp_r;
			CMB_SEL_LMASK: rd_nxt = lmask_r;
			CMB_SEL_GMASK: rd_nxt = gmask_r;
			CMB_SEL_RMP:   rd_nxt = rmp_r;
			CMB_SEL_TSC:   rd_nxt = {16'h0, ts_r};
			default:       rd_nxt = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// acceptance and winner selection
	genvar gi;
	generate
		for (gi = 0; gi < NMB; gi++) begin : g_flat
			assign id_flat[gi*32 +: 32] = id_r[gi];
		end
	endgenerate

	cmb_accept #(.NMB(NMB)) u_accept (
		.id_flat (id_flat),
		.en      (en_r[NMB-1:0]),
		.dir_rx  (dir_r[NMB-1:0]),
		.gmask   (gmask_r),
		.lmask   (lmask_r),
		.rx_ide  (rx_ide),
		.rx_rtr  (rx_rtr),
		.rx_id   (rx_id),
		.hit     (hit)
	);

	// lowest numbered hit takes the frame
	always_comb begin
		rx_any = 1'b0;
		rx_win = 5'h0;
		for (int k = NMB-1; k >= 0; k--) begin
			if (hit[k]) begin
				rx_any = 1'b1;
				rx_win = 5'(k);
			end
		end
	end

	wire rx_take  = rx_valid && rx_any;
	wire win_rx   = dir_r[rx_win];
	wire win_arr  = id_r[rx_win][`CMB_F_ARR];
	wire win_msk  = id_r[rx_win][`CMB_F_MSKEN];
	// receive mailboxes keep data and remote frames alike
	wire rx_store = rx_take && win_rx;
	// without auto reply the remote request is left to software
	wire auto_rep = rx_take && !win_rx && win_arr;
	// masked receive stores the id it got; masked auto reply answers with it
	wire id_repl  = (rx_store || auto_rep) && win_msk;
	wire tx_good  = tx_done && tx_ok;
	wire [31:0] win_1h = 32'h1 << rx_win;
	wire [31:0] tx_1h  = 32'h1 << tx_mbox;

	////////////////////////////////////////////////////////////////
	// mailbox words; hardware updates win over software in a cycle
	always_ff @(posedge pclk) begin
		if (wr_id && id_ok)
			id_r[mb] <= pwdata;
		if (wr_ctl && ctl_ok)
			ctl_r[mb] <= pwdata & `CMB_CTL_WMASK;
		if (id_repl)
			id_r[rx_win] <= {id_r[rx_win][31:29], rx_id};
		if (rx_store)
			ctl_r[rx_win] <= {ts_r, 11'h0, rx_rtr, rx_dlc};
		// a failed transfer leaves the stamp alone
		if (tx_good)
			ctl_r[tx_mbox][31:`CMB_TS_LSB] <= ts_r;
	end

	////////////////////////////////////////////////////////////////
	// flags: set wins over clear
	assign treq_nxt = (treq_r & ~(wr_tclr | (tx_good ? tx_1h : 32'h0)))
		| wr_set | (auto_rep ? win_1h : 32'h0);
	assign rxp_nxt  = (rxp_r & ~wr_rxc) | (rx_store ? win_1h : 32'h0);
	assign rmp_nxt  = (rmp_r & ~wr_rmc) | ((rx_store && rx_rtr) ? win_1h : 32'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			treq_r <= 32'h0;
			rxp_r  <= 32'h0;
			rmp_r  <= 32'h0;
		end else begin
			treq_r <= treq_nxt;
			rxp_r  <= rxp_nxt;
			rmp_r  <= rmp_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r    <= `CMB_EN_RST;
			dir_r   <= `CMB_DIR_RST;
			gmask_r <= `CMB_MASK_RST;
			lmask_r <= `CMB_MASK_RST;
		end else if (wr) begin
			if (sel == CMB_SEL_EN)
				en_r <= pwdata;
			if (sel == CMB_SEL_DIR)
				dir_r <= pwdata;
			if (sel == CMB_SEL_GMASK)
				gmask_r <= pwdata;
			if (sel == CMB_SEL_LMASK)
				lmask_r <= pwdata;
		end
	end

	// free-running stamp, one count per clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ts_r <= 16'h0;
		else
			ts_r <= ts_r + 16'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (setup)
			prdata_r <= rd_nxt;
	end

	////////////////////////////////////////////////////////////////
	// transmit selection, registered toward the bit engine
	wire [NMB-1:0] cand = treq_r[NMB-1:0] & en_r[NMB-1:0] & ~dir_r[NMB-1:0];

	cmb_id_prio #(.NMB(NMB)) u_prio (
		.id_flat (id_flat),
		.cand    (cand),
		.any     (pr_any),
		.sel     (pr_sel)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pend_r <= 1'b0;
			tx_sel_r  <= 5'h0;
			tx_ide_r  <= 1'b0;
			tx_rtr_r  <= 1'b0;
			tx_id_r   <= 29'h0;
			tx_dlc_r  <= 4'h0;
		end else begin
			tx_pend_r <= pr_any;
			tx_sel_r  <= pr_sel;
			tx_ide_r  <= id_r[pr_sel][`CMB_F_IDE];
			tx_rtr_r  <= ctl_r[pr_sel][`CMB_F_RTR];
			tx_id_r   <= id_r[pr_sel][28:0];
			tx_dlc_r  <= ctl_r[pr_sel][3:0];
		end
	end

	assign tx_pend = tx_pend_r;
	assign tx_sel  = tx_sel_r;
	assign tx_ide  = tx_ide_r;
	assign tx_rtr  = tx_rtr_r;
	assign tx_id   = tx_id_r;
	assign tx_dlc  = tx_dlc_r;
	assign mbox_en = en_r;
	assign treq    = treq_r;
	assign rxpend  = rxp_r;
	assign rmtpend = rmp_r;
	assign tstamp  = ts_r;

	////////////////////////////////////////////////////////////////
	// checks
	logic        chk_blk_q;
	cmb_mbx_t    chk_idx_q;
	logic [31:0] chk_val_q;
	// helper state for the locked control and failed transfer checks
	logic        chk_cblk_r;
	logic [31:0] chk_cval_r;
	logic        chk_fail_r;
	cmb_mbx_t    chk_fidx_r;
	logic [15:0] chk_fts_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_blk_q <= 1'b0;
			chk_idx_q <= 5'h0;
			chk_val_q <= 32'h0;
			chk_cblk_r <= 1'b0;
			chk_cval_r <= 32'h0;
			chk_fail_r <= 1'b0;
			chk_fidx_r <= 5'h0;
			chk_fts_r  <= 16'h0;
		end else begin
			chk_blk_q <= wr_id && !id_ok && !(id_repl && rx_win == mb);
			chk_idx_q <= mb;
			chk_val_q <= id_r[mb];
			chk_cblk_r <= wr_ctl && !ctl_ok && !(rx_store && rx_win == mb) && !(tx_good && tx_mbox == mb);
			chk_cval_r <= ctl_r[mb];
			// a failed transfer must leave the stamp alone unless something else writes it
			chk_fail_r <= tx_done && !tx_ok && !(rx_store && rx_win == tx_mbox) && !(wr_ctl && ctl_ok && mb == tx_mbox);
			chk_fidx_r <= tx_mbox;
			chk_fts_r  <= ctl_r[tx_mbox][31:16];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_remote_hit;
		rx_valid && rx_any && !win_rx && win_arr;
	endsequence
	sequence s_rx_store;
		rx_valid && rx_any && win_rx;
	endsequence

	id_lock_a: assert property (chk_blk_q |-> id_r[chk_idx_q] == chk_val_q)
		else $error("identifier changed while mailbox enabled");
	auto_treq_a: assert property (s_remote_hit |=> treq_r[$past(rx_win)])
		else $error("auto reply did not raise transmit request");
	no_auto_a: assert property (rx_take && !win_rx && !win_arr && !wr && !tx_done
		|=> $stable(treq_r))
		else $error("remote frame answered without auto reply");
	id_repl_a: assert property (s_remote_hit ##0 win_msk
		|=> id_r[$past(rx_win)][28:0] == $past(rx_id))
		else $error("identifier not replaced by remote id");
	rx_flags_a: assert property (s_rx_store ##0 rx_rtr
		|=> rxp_r[$past(rx_win)] && rmp_r[$past(rx_win)])
		else $error("remote frame flags not set");
	rx_ctl_a: assert property (s_rx_store |=> ctl_r[$past(rx_win)][3:0] == $past(rx_dlc)
		&& ctl_r[$past(rx_win)][`CMB_F_RTR] == $past(rx_rtr))
		else $error("control field not stored on receive");
	stamp_copy_a: assert property (tx_good |=> ctl_r[$past(tx_mbox)][31:16] == $past(ts_r))
		else $error("stamp not captured on transmit");
	treq_done_a: assert property (tx_good && !auto_rep && wr_set == 32'h0
		|=> !treq_r[$past(tx_mbox)])
		else $error("request bit still set after transmit");
	resv_zero_a: assert property (setup && sel == CMB_SEL_CTL
		|=> prdata_r[15:5] == 11'h0)
		else $error("reserved control bits not zero");
	tx_pick_a: assert property (cand != '0 |=> tx_pend_r ##0 $past(cand[pr_sel]))
		else $error("pending transmit not selected");
	ctl_lock_a: assert property (chk_cblk_r |-> ctl_r[chk_idx_q] == chk_cval_r)
		else $error("control changed while locked");
	rx_stamp_a: assert property (s_rx_store |=> ctl_r[$past(rx_win)][31:16] == $past(ts_r))
		else $error("stamp not captured on receive");
	stamp_keep_a: assert property (chk_fail_r |-> ctl_r[chk_fidx_r][31:16] == chk_fts_r)
		else $error("stamp changed by failed transfer");
endmodule

// [verif/cmb_bus_model.sv]
`timescale 1ns/1ps
module cmb_bus_model import cmb_pkg::*; (
	input  logic        pclk,
	input  logic        tx_pend,
	input  cmb_mbx_t    tx_sel,
	output logic        rx_valid,
	output logic        rx_ide,
	output logic        rx_rtr,
	output logic [28:0] rx_id,
	output logic [3:0]  rx_dlc,
	output logic        tx_done,
	output logic        tx_ok,
	output cmb_mbx_t    tx_mbox
);
	initial begin
		{rx_valid, rx_ide, rx_rtr, rx_id, rx_dlc} = '0;
		{tx_done, tx_ok, tx_mbox} = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// fields are scrambled after the frame so nothing can lean on stale values
	task automatic frame(input logic ide, input logic rtr, input logic [28:0] id, input logic [3:0] dlc);
		@(posedge pclk);
		rx_valid <= 1'h1;
		{rx_ide, rx_rtr, rx_id, rx_dlc} <= {ide, rtr, id, dlc};
		@(posedge pclk);
		rx_valid <= 1'h0;
		{rx_ide, rx_rtr, rx_id, rx_dlc} <= ~{ide, rtr, id, dlc};
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// ok low models a transfer lost on the wire; dly idle cycles model a busy bus
	task automatic finish(input logic ok, input int dly);
		cmb_mbx_t m;
		repeat (2) @(negedge pclk);
		for (int i = 0; i < 40 && tx_pend !== 1'h1; i++) @(negedge pclk);
		m = tx_sel;
		repeat (dly) @(negedge pclk);
		@(posedge pclk);
		tx_done <= 1'h1;
		tx_ok   <= ok;
		tx_mbox <= m;
		@(posedge pclk);
		tx_done <= 1'h0;
		tx_ok   <= ~ok;
		tx_mbox <= ~m;
	endtask
endmodule

// [verif/cmb_mailbox_tb.sv]
`timescale 1ns/1ps
`include "cmb_regs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module cmb_mailbox_tb import cmb_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mbox_en, treq, rxpend, rmtpend, rd;
	logic        rx_valid, rx_ide, rx_rtr, tx_done, tx_ok, tx_pend, tx_ide, tx_rtr;
	logic [28:0] rx_id, tx_id;
	logic [3:0]  rx_dlc, tx_dlc;
	logic [15:0] tstamp, stamp_exp;
	cmb_mbx_t    tx_mbox, tx_sel;
	int          error_cnt, n_compared;

	cmb_mailbox #(.NMB(32)) i_cmb_mailbox (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc), .tx_done(tx_done), .tx_ok(tx_ok),
		.tx_mbox(tx_mbox), .tx_pend(tx_pend), .tx_sel(tx_sel), .tx_ide(tx_ide), .tx_rtr(tx_rtr),
		.tx_id(tx_id), .tx_dlc(tx_dlc),
		.mbox_en(mbox_en), .treq(treq), .rxpend(rxpend), .rmtpend(rmtpend), .tstamp(tstamp));
	cmb_bus_model i_cmb_bus_model (
		.pclk(pclk), .tx_pend(tx_pend), .tx_sel(tx_sel), .rx_valid(rx_valid), .rx_ide(rx_ide),
		.rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc), .tx_done(tx_done), .tx_ok(tx_ok), .tx_mbox(tx_mbox));

	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] mb(input cmb_mbx_t m, input logic [4:0] o);
		return {`CMB_MB_PAGE, m, o};
	endfunction
	function automatic logic [11:0] gl(input logic [7:0] o);
		return {`CMB_GLB_PAGE, o};
	endfunction
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdc(gl(`CMB_OFF_EN), `CMB_EN_RST);
		rdc(gl(`CMB_OFF_DIR), `CMB_DIR_RST);
		rdc(gl(`CMB_OFF_GMASK), `CMB_MASK_RST);
		rdc(gl(`CMB_OFF_TQSET), 32'h0000_0000);
		rdc(12'h4F0, 32'h0000_0000);
		`CHK(err, 1'h1)
		// read data is loaded one edge before the edge at which the task returns
		xfer(1'h0, gl(`CMB_OFF_TSC), 32'h0);
		`CHK(rd, {16'h0, tstamp - 16'h1})
	endtask
	task automatic t_fields();
		wr(mb(5'h01, `CMB_OFF_ID), 32'hE123_4567);
		rdc(mb(5'h01, `CMB_OFF_ID), 32'hE123_4567);
		wr(mb(5'h01, `CMB_OFF_CTL), 32'hABCD_0015);
		rdc(mb(5'h01, `CMB_OFF_CTL), 32'hABCD_0015);
		wr(mb(5'h01, `CMB_OFF_CTL), 32'h1234_000A);
		rdc(mb(5'h01, `CMB_OFF_CTL), 32'h1234_000A);
	endtask
	// writes while enabled are attempted on purpose and must bounce off
	task automatic t_lock();
		wr(gl(`CMB_OFF_EN), 32'h0000_0002);
		#1 `CHK(mbox_en, 32'h0000_0002)
		wr(mb(5'h01, `CMB_OFF_ID), 32'h0000_0001);
		rdc(mb(5'h01, `CMB_OFF_ID), 32'hE123_4567);
		wr(mb(5'h01, `CMB_OFF_CTL), 32'h0000_0000);
		rdc(mb(5'h01, `CMB_OFF_CTL), 32'h1234_000A);
		wr(gl(`CMB_OFF_EN), 32'h0000_0000);
		wr(mb(5'h01, `CMB_OFF_ID), 32'h8000_0001);
		rdc(mb(5'h01, `CMB_OFF_ID), 32'h8000_0001);
	endtask
	task automatic t_rx();
		wr(gl(`CMB_OFF_DIR), 32'h8000_0004);
		wr(mb(5'h02, `CMB_OFF_ID), 32'h048C_0000);
		wr(gl(`CMB_OFF_EN), 32'h0000_0004);
		i_cmb_bus_model.frame(1'h1, 1'h0, 29'h048C_0000, 4'h3);
		i_cmb_bus_model.frame(1'h0, 1'h0, 29'h0488_0000, 4'h3);
		#1 `CHK(rxpend, 32'h0000_0000)
		i_cmb_bus_model.frame(1'h0, 1'h1, 29'h048F_FFFF, 4'h5);
		#1 `CHK(rxpend, 32'h0000_0004)
		`CHK(rmtpend, 32'h0000_0004)
		stamp_exp = tstamp - 16'h1;
		rdc(mb(5'h02, `CMB_OFF_CTL), {stamp_exp, 16'h0015});
		wr(gl(`CMB_OFF_RXPEND), 32'h0000_0004);
		wr(gl(`CMB_OFF_RMPEND), 32'h0000_0004);
		#1 `CHK(rxpend | rmtpend, 32'h0000_0000)
	endtask
	task automatic t_mask();
		wr(gl(`CMB_OFF_DIR), 32'h8000_0010);
		wr(mb(5'h04, `CMB_OFF_ID), 32'hC000_0100);
		wr(mb(5'h1F, `CMB_OFF_ID), 32'hC000_00F0);
		wr(gl(`CMB_OFF_GMASK), 32'h0000_000F);
		wr(gl(`CMB_OFF_EN), 32'h8000_0010);
		i_cmb_bus_model.frame(1'h1, 1'h0, 29'h0000_00F5, 4'h1);
		i_cmb_bus_model.frame(1'h1, 1'h0, 29'h0000_0105, 4'h1);
		#1 `CHK(rxpend, 32'h0000_0010)
		wr(gl(`CMB_OFF_LMASK), 32'h0000_000F);
		i_cmb_bus_model.frame(1'h1, 1'h0, 29'h0000_00F5, 4'h1);
		#1 `CHK(rxpend, 32'h8000_0010)
		wr(gl(`CMB_OFF_RXPEND), 32'hFFFF_FFFF);
	endtask
	task automatic t_tx();
		wr(gl(`CMB_OFF_DIR), 32'h8000_0000);
		wr(gl(`CMB_OFF_GMASK), 32'h0000_00FF);
		wr(mb(5'h05, `CMB_OFF_ID), 32'hE000_4000);
		wr(mb(5'h06, `CMB_OFF_ID), 32'h8000_2000);
		wr(mb(5'h05, `CMB_OFF_CTL), 32'h0000_0003);
		wr(mb(5'h06, `CMB_OFF_CTL), 32'h0000_0003);
		wr(gl(`CMB_OFF_EN), 32'h0000_0060);
		i_cmb_bus_model.frame(1'h1, 1'h1, 29'h0000_2000, 4'h0);
		#1 `CHK(treq, 32'h0000_0000)
		i_cmb_bus_model.frame(1'h1, 1'h1, 29'h0000_4042, 4'h0);
		#1 `CHK(treq, 32'h0000_0020)
		rdc(mb(5'h05, `CMB_OFF_ID), 32'hE000_4042);
		#1 `CHK(tx_sel, 5'h05)
		`CHK({tx_ide, tx_rtr, tx_dlc}, 6'h23)
		`CHK(tx_id, 29'h0000_4042)
		i_cmb_bus_model.finish(1'h0, 0);
		#1 `CHK(treq, 32'h0000_0020)
		rdc(mb(5'h05, `CMB_OFF_CTL), 32'h0000_0003);
		i_cmb_bus_model.finish(1'h1, 3);
		#1 `CHK(treq, 32'h0000_0000)
		stamp_exp = tstamp - 16'h1;
		rdc(mb(5'h05, `CMB_OFF_CTL), {stamp_exp, 16'h0003});
		// both pending at once: the longer zero run from bit 28 wins even against the lower number
		wr(gl(`CMB_OFF_TQSET), 32'h0000_0060);
		repeat (2) @(posedge pclk);
		#1 `CHK(tx_sel, 5'h06)
		`CHK(tx_id, 29'h0000_2000)
		i_cmb_bus_model.finish(1'h1, 0);
		#1 `CHK(treq, 32'h0000_0020)
		i_cmb_bus_model.finish(1'h1, 0);
		#1 `CHK(treq, 32'h0000_0000)
		// no auto reply: control may change while enabled, whatever the request bit reads
		rdc(gl(`CMB_OFF_TQCLR), 32'h0000_0000);
		wr(mb(5'h06, `CMB_OFF_CTL), 32'h0000_0012);
		rdc(mb(5'h06, `CMB_OFF_CTL), 32'h0000_0012);
		wr(gl(`CMB_OFF_TQSET), 32'h0000_0040);
		repeat (2) @(posedge pclk);
		#1 `CHK(tx_sel, 5'h06)
		`CHK({tx_ide, tx_rtr, tx_dlc}, 6'h32)
		i_cmb_bus_model.finish(1'h1, 0);
		#1 `CHK(treq, 32'h0000_0000)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn    = 1'h0;
		error_cnt  = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		`CHK(tstamp, 16'h0)
		presetn <= 1'h1;
		t_reset();
		t_fields();
		t_lock();
		t_rx();
		t_mask();
		t_tx();
		summarize();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
endmodule
